// ### servo_setup_pulse_config.sv
// servo setup word store, decode, command pulse counting and stop control
`timescale 1ns/1ps
module servo_setup_pulse_config (
  // clock and full reset
  input  wire logic                          clk,
  input  wire logic                          rst,
  // operator unit access to the stored setup words
  input  wire logic                          wr_one,
  input  wire logic                          wr_two,
  input  wire logic [15:0]                   wr_data,
  input  wire logic                          factory_init,
  input  wire logic                          power_cycle,
  output logic [15:0]                        word_one_rd,
  output logic [15:0]                        word_two_rd,
  // asynchronous pins
  input  wire logic                          motor_large_pin,
  input  wire servo_cfg_pkg::pulse_pins_type feed_pulse_input,
  input  wire logic                          dev_clear_pin,
  // drive status from the control core
  input  wire servo_cfg_pkg::ctrl_mode_type  ctrl_mode,
  input  wire logic                          run_cmd,
  input  wire logic                          sensor_on_in,
  input  wire logic                          fwd_prohibit,
  input  wire logic                          rev_prohibit,
  input  wire logic                          alarm,
  input  wire logic                          overtravel,
  input  wire logic                          motor_stopped,
  input  wire logic                          origin_err_raw,
  input  wire logic                          fb_step_up,
  input  wire logic                          fb_step_dn,
  // command counting
  output logic                               cmd_step_up,
  output logic                               cmd_step_dn,
  output servo_cfg_pkg::dev_type             deviation,
  // decoded settings
  output logic                               servo_on,
  output logic                               drive_fwd_ok,
  output logic                               drive_rev_ok,
  output servo_cfg_pkg::mon1_src_type        first_monitor_output,
  output servo_cfg_pkg::mon2_src_type        second_monitor_output,
  output servo_cfg_pkg::mode_flags_type      flags,
  output logic [1:0]                         psw_cond,
  // stop process
  output servo_cfg_pkg::stop_out_type        stop_out
);

  typedef enum logic [2:0] {ST_RUN, ST_ABN_STOP, ST_OT_STOP, ST_ABN_HELD, ST_OT_HELD} stop_state_type;

  // stored (operator-visible) and effective copies of the setup words
  logic [15:0]                   one_q;
  logic [15:0]                   two_q;
  logic [15:0]                   eff_one_q;
  logic [15:0]                   eff_two_q;
  logic [1:0]                    init_cnt_q;
  logic                          init_load;
  logic [15:0]                   one_factory;

  // two-stage synchroniser for the four pins
  logic [3:0]                    sync1_q;
  logic [3:0]                    sync2_q;
  servo_cfg_pkg::pulse_pins_type pins_s;
  logic                          large_s;
  logic                          clr_s;
  logic                          clr_prev_q;

  // effective fields
  wire [15:0]                    two_live;
  wire [2:0]                     pulse_mode;
  wire                           is_pos;
  wire                           is_spd;
  wire                           is_trq;
  wire                           brake_valid;
  wire                           brake_after;
  wire                           ot_by_free;
  wire                           servo_req;
  wire                           abnormal;
  wire                           clr_hit;
  wire                           servo_off_clr;
  wire                           dev_clr;
  logic                          up_s;
  logic                          dn_s;

  servo_cfg_pkg::dev_type        dev_q;
  servo_cfg_pkg::dev_type        dev_d;

  stop_state_type                st_q;
  stop_state_type                st_d;
  servo_cfg_pkg::stop_out_type   stop_d;

  servo_cfg_pkg::mon1_src_type   mon1_d;
  servo_cfg_pkg::mon2_src_type   mon2_d;
  servo_cfg_pkg::mode_flags_type flags_d;

  // ---------------------------------------------------------------
  // pin synchronisation
  always_ff @(posedge clk) begin
    if (rst) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else begin
      sync1_q <= {motor_large_pin, dev_clear_pin, feed_pulse_input.a, feed_pulse_input.b};
      sync2_q <= sync1_q;
    end
  end

  assign pins_s.b = sync2_q[0];
  assign pins_s.a = sync2_q[1];
  assign clr_s    = sync2_q[2];
  assign large_s  = sync2_q[3];

  // ---------------------------------------------------------------
  // setup word storage
  // the strap is sampled only once the synchroniser has filled
  assign init_load   = (init_cnt_q == 2'h1);
  assign one_factory = servo_cfg_pkg::W1_FACTORY
                     | (16'h0001 << servo_cfg_pkg::W1_BRAKE_HOLD) & {16{~large_s}};

  always_ff @(posedge clk) begin
    if (rst) begin
      init_cnt_q <= servo_cfg_pkg::INIT_DLY;
    end else if (init_cnt_q != 2'h0) begin
      init_cnt_q <= init_cnt_q - 2'h1;
    end
  end

  // reserved bits are stored as written; keeping them at factory is the operator's duty
  always_ff @(posedge clk) begin
    if (rst) begin
      one_q <= servo_cfg_pkg::W1_FACTORY;
      two_q <= servo_cfg_pkg::W2_FACTORY;
    end else if (init_load || factory_init) begin
      one_q <= one_factory;
      two_q <= servo_cfg_pkg::W2_FACTORY;
    end else begin
      if (wr_one) begin
        one_q <= wr_data;
      end
      if (wr_two) begin
        two_q <= wr_data;
      end
    end
  end

  // written words only reach the logic at a power reset, apart from the word two monitor routing bits
  always_ff @(posedge clk) begin
    if (rst) begin
      eff_one_q <= servo_cfg_pkg::W1_FACTORY;
      eff_two_q <= servo_cfg_pkg::W2_FACTORY;
    end else if (init_load) begin
      eff_one_q <= one_factory;
      eff_two_q <= servo_cfg_pkg::W2_FACTORY;
    end else if (power_cycle) begin
      eff_one_q <= one_q;
      eff_two_q <= two_q;
    end
  end

  assign word_one_rd = one_q;
  assign word_two_rd = two_q;

  // monitor routing bits follow the stored word at once
  assign two_live = {eff_two_q[15:8], two_q[servo_cfg_pkg::W2_MON2], two_q[servo_cfg_pkg::W2_MON1],
                     eff_two_q[5:0]};

  assign pulse_mode = two_live[servo_cfg_pkg::W2_PMODE_HI:servo_cfg_pkg::W2_PMODE_LO];
  assign is_pos     = (ctrl_mode == servo_cfg_pkg::CTRL_POSITION);
  assign is_spd     = (ctrl_mode == servo_cfg_pkg::CTRL_SPEED);
  assign is_trq     = (ctrl_mode == servo_cfg_pkg::CTRL_TORQUE);

  // ---------------------------------------------------------------
  // command pulse decode
  cmd_pulse_decode u_decode (
    .clk     (clk),
    .rst     (rst),
    .pins    (pins_s),
    .mode    (pulse_mode),
    .invert  (two_live[servo_cfg_pkg::W2_PULSE_NEG]),
    .reverse (two_live[servo_cfg_pkg::W2_REVERSE]),
    .step_up (up_s),
    .step_dn (dn_s)
  );

  assign cmd_step_up = up_s;
  assign cmd_step_dn = dn_s;

  // ---------------------------------------------------------------
  // deviation counter
  assign clr_hit = two_live[servo_cfg_pkg::W2_CLR_EDGE] ? (clr_s & ~clr_prev_q) : clr_s;
  assign servo_off_clr = ~eff_one_q[servo_cfg_pkg::W1_KEEP_DEV]
                       & ((st_q == ST_ABN_STOP) || (st_q == ST_ABN_HELD));
  assign dev_clr = (is_pos & clr_hit) | servo_off_clr;

  // wraps silently; overflow supervision belongs to the alarm logic
  assign dev_d = dev_q
               + servo_cfg_pkg::dev_type'(up_s)
               + servo_cfg_pkg::dev_type'(fb_step_dn)
               - servo_cfg_pkg::dev_type'(dn_s)
               - servo_cfg_pkg::dev_type'(fb_step_up);

  always_ff @(posedge clk) begin
    if (rst) begin
      clr_prev_q <= 1'b0;
      dev_q      <= '0;
    end else begin
      clr_prev_q <= clr_s;
      dev_q      <= dev_clr ? '0 : dev_d;
    end
  end

  assign deviation = dev_q;

  // ---------------------------------------------------------------
  // sequence inputs
  assign servo_req = (eff_one_q[servo_cfg_pkg::W1_ALWAYS_ON] | run_cmd)
                   & (eff_one_q[servo_cfg_pkg::W1_SENSOR_ON] | sensor_on_in);
  assign abnormal  = ~servo_req | alarm;

  // ---------------------------------------------------------------
  // stop process
  assign brake_valid = ~large_s;
  assign brake_after = brake_valid & eff_one_q[servo_cfg_pkg::W1_BRAKE_HOLD]
                     & ~(eff_one_q[servo_cfg_pkg::W1_FREE_RUN] & ~eff_one_q[servo_cfg_pkg::W1_OT_TORQUE]);
  assign ot_by_free  = ~eff_one_q[servo_cfg_pkg::W1_OT_TORQUE] | is_trq;

  always_comb begin
    st_d = st_q;
    unique case (st_q)
      ST_RUN: begin
        if (abnormal) begin
          st_d = ST_ABN_STOP;
        end else if (overtravel) begin
          st_d = ST_OT_STOP;
        end
      end
      ST_ABN_STOP: begin
        if (motor_stopped) begin
          st_d = ST_ABN_HELD;
        end
      end
      ST_ABN_HELD: begin
        if (!abnormal) begin
          st_d = ST_RUN;
        end
      end
      ST_OT_STOP: begin
        if (abnormal) begin
          st_d = ST_ABN_STOP;
        end else if (motor_stopped) begin
          st_d = ST_OT_HELD;
        end
      end
      ST_OT_HELD: begin
        if (abnormal) begin
          st_d = ST_ABN_STOP;
        end else if (!overtravel) begin
          st_d = ST_RUN;
        end
      end
    endcase
  end

  always_comb begin
    stop_d = '0;
    unique case (st_d)
      ST_RUN: begin
        stop_d = '0;
      end
      ST_ABN_STOP: begin
        stop_d.servo_off = 1'b1;
        stop_d.dyn_brake = ~eff_one_q[servo_cfg_pkg::W1_FREE_RUN];
        stop_d.free_run  = eff_one_q[servo_cfg_pkg::W1_FREE_RUN];
      end
      ST_ABN_HELD: begin
        stop_d.servo_off = 1'b1;
        stop_d.dyn_brake = brake_after;
      end
      ST_OT_STOP: begin
        stop_d.torque_stop = ~ot_by_free;
        stop_d.servo_off   = ot_by_free;
        stop_d.dyn_brake   = ot_by_free & ~eff_one_q[servo_cfg_pkg::W1_FREE_RUN];
        stop_d.free_run    = ot_by_free & eff_one_q[servo_cfg_pkg::W1_FREE_RUN];
      end
      ST_OT_HELD: begin
        stop_d.pos_lock  = eff_one_q[servo_cfg_pkg::W1_OT_LOCK];
        stop_d.servo_off = ~eff_one_q[servo_cfg_pkg::W1_OT_LOCK];
        stop_d.dyn_brake = ~eff_one_q[servo_cfg_pkg::W1_OT_LOCK] & brake_after;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_q     <= ST_RUN;
      stop_out <= '0;
    end else begin
      st_q     <= st_d;
      stop_out <= stop_d;
    end
  end

  // ---------------------------------------------------------------
  // decoded settings and monitor routing
  always_comb begin
    mon1_d = servo_cfg_pkg::MON1_CURRENT;
    if (two_live[servo_cfg_pkg::W2_MON1]) begin
      mon1_d = is_pos ? servo_cfg_pkg::MON1_PULSE_SPEED
             : is_spd ? servo_cfg_pkg::MON1_SPEED_CMD
             : servo_cfg_pkg::MON1_ZERO;
    end
    mon2_d = servo_cfg_pkg::MON2_SPEED;
    if (two_live[servo_cfg_pkg::W2_MON2]) begin
      mon2_d = is_pos ? servo_cfg_pkg::MON2_DEVIATION : servo_cfg_pkg::MON2_ZERO;
    end
  end

  assign flags_d.speed_lim_en    = is_trq & two_live[servo_cfg_pkg::W2_SPD_LIM];
  assign flags_d.current_lim_en  = is_spd & two_live[servo_cfg_pkg::W2_TORQUE_REFERENCE_INPUT_LIM];
  assign flags_d.torque_ff_en    = is_spd & two_live[servo_cfg_pkg::W2_TRQ_FF];
  assign flags_d.psw_en          = ~is_trq & ~eff_one_q[servo_cfg_pkg::W1_NO_PSW];
  assign flags_d.torque_filt_2nd = two_live[servo_cfg_pkg::W2_TRQ_FILT];
  assign flags_d.dev_mon_x100    = two_live[servo_cfg_pkg::W2_DEV_X100];
  assign flags_d.absolute_enc    = eff_one_q[servo_cfg_pkg::W1_ABS_ENC];
  assign flags_d.origin_err      = origin_err_raw & eff_one_q[servo_cfg_pkg::W1_ABS_ENC]
                                 & ~two_live[servo_cfg_pkg::W2_ORIGIN_MASK];

  always_ff @(posedge clk) begin
    if (rst) begin
      first_monitor_output  <= servo_cfg_pkg::MON1_CURRENT;
      second_monitor_output <= servo_cfg_pkg::MON2_SPEED;
      flags                 <= '0;
      psw_cond              <= 2'h0;
      servo_on              <= 1'b0;
      drive_fwd_ok          <= 1'b0;
      drive_rev_ok          <= 1'b0;
    end else begin
      first_monitor_output  <= mon1_d;
      second_monitor_output <= mon2_d;
      flags                 <= flags_d;
      psw_cond              <= eff_one_q[servo_cfg_pkg::W1_PSW_HI:servo_cfg_pkg::W1_PSW_LO];
      servo_on              <= (st_d == ST_RUN) | (st_d == ST_OT_HELD & eff_one_q[servo_cfg_pkg::W1_OT_LOCK]);
      drive_fwd_ok          <= eff_one_q[servo_cfg_pkg::W1_FWD_OK] | ~fwd_prohibit;
      drive_rev_ok          <= eff_one_q[servo_cfg_pkg::W1_REV_OK] | ~rev_prohibit;
    end
  end

endmodule

// ### servo_cfg_pkg.sv
// shared constants and types for the servo setup word decode
package servo_cfg_pkg;

  localparam int WORD_W = 16;
  localparam int DEV_W  = 16;

  // setup word one field positions
  localparam int W1_ALWAYS_ON  = 0;
  localparam int W1_SENSOR_ON  = 1;
  localparam int W1_FWD_OK     = 2;
  localparam int W1_REV_OK     = 3;
  localparam int W1_FREE_RUN   = 6;
  localparam int W1_BRAKE_HOLD = 7;
  localparam int W1_OT_TORQUE  = 8;
  localparam int W1_OT_LOCK    = 9;
  localparam int W1_KEEP_DEV   = 10;
  localparam int W1_NO_PSW     = 11;
  localparam int W1_PSW_LO     = 12;
  localparam int W1_PSW_HI     = 13;
  localparam int W1_ABS_ENC    = 14;

  // setup word two field positions
  localparam int W2_REVERSE     = 0;
  localparam int W2_ORIGIN_MASK = 1;
  localparam int W2_SPD_LIM     = 2;
  localparam int W2_PMODE_LO    = 3;
  localparam int W2_PMODE_HI    = 5;
  localparam int W2_MON1        = 6;
  localparam int W2_MON2        = 7;
  localparam int W2_TORQUE_REFERENCE_INPUT_LIM    = 8;
  localparam int W2_TRQ_FF      = 9;
  localparam int W2_CLR_EDGE    = 10;
  localparam int W2_TRQ_FILT    = 12;
  localparam int W2_PULSE_NEG   = 13;
  localparam int W2_DEV_X100    = 14;

  // factory values; word one bit 7 is added from the motor size strap
  localparam logic [WORD_W-1:0] W1_FACTORY = 16'h084C;
  localparam logic [WORD_W-1:0] W2_FACTORY = 16'h0408;

  // command pulse format codes
  localparam logic [2:0] PM_PULSE_DIR = 3'h0;
  localparam logic [2:0] PM_FWD_REV   = 3'h1;
  localparam logic [2:0] PM_QUAD_X1   = 3'h2;
  localparam logic [2:0] PM_QUAD_X2   = 3'h3;
  localparam logic [2:0] PM_QUAD_X4   = 3'h4;

  // cycles to wait after reset before sampling the strap
  localparam logic [1:0] INIT_DLY = 2'h3;

  typedef logic [DEV_W-1:0] dev_type;

  typedef enum logic [1:0] {CTRL_POSITION, CTRL_SPEED, CTRL_TORQUE} ctrl_mode_type;
  typedef enum logic [1:0] {MON1_CURRENT, MON1_PULSE_SPEED, MON1_SPEED_CMD, MON1_ZERO} mon1_src_type;
  typedef enum logic [1:0] {MON2_SPEED, MON2_DEVIATION, MON2_ZERO} mon2_src_type;

  typedef struct packed {
    logic a;
    logic b;
  } pulse_pins_type;

  typedef struct packed {
    logic dyn_brake;
    logic free_run;
    logic torque_stop;
    logic servo_off;
    logic pos_lock;
  } stop_out_type;

  typedef struct packed {
    logic speed_lim_en;
    logic current_lim_en;
    logic torque_ff_en;
    logic psw_en;
    logic torque_filt_2nd;
    logic dev_mon_x100;
    logic absolute_enc;
    logic origin_err;
  } mode_flags_type;

endpackage

// ### cmd_pulse_decode.sv
// command pulse input decoder: format, polarity and count direction
`timescale 1ns/1ps
module cmd_pulse_decode (
  // clock and reset
  input  wire logic                          clk,
  input  wire logic                          rst,
  // synchronised pulse pins and settings
  input  wire servo_cfg_pkg::pulse_pins_type pins,
  input  wire logic [2:0]                    mode,
  input  wire logic                          invert,
  input  wire logic                          reverse,
  // one-cycle count steps
  output logic                               step_up,
  output logic                               step_dn
);

  servo_cfg_pkg::pulse_pins_type cur;
  servo_cfg_pkg::pulse_pins_type prev_q;
  logic                          armed_q;
  logic                          up;
  logic                          dn;
  wire                           a_rise;
  wire                           b_rise;
  wire                           a_edge;
  wire                           b_edge;

  assign cur.a  = pins.a ^ invert;
  assign cur.b  = pins.b ^ invert;
  assign a_rise = cur.a & ~prev_q.a;
  assign b_rise = cur.b & ~prev_q.b;
  assign a_edge = cur.a ^ prev_q.a;
  assign b_edge = cur.b ^ prev_q.b;

  // direction in quadrature: a leading b gives up counts
  always_comb begin
    up = 1'b0;
    dn = 1'b0;
    unique case (mode)
      servo_cfg_pkg::PM_PULSE_DIR: begin
        up = a_rise & ~cur.b;
        dn = a_rise & cur.b;
      end
      servo_cfg_pkg::PM_FWD_REV: begin
        up = a_rise;
        dn = b_rise;
      end
      servo_cfg_pkg::PM_QUAD_X1: begin
        up = a_rise & ~cur.b;
        dn = a_rise & cur.b;
      end
      servo_cfg_pkg::PM_QUAD_X2: begin
        up = a_edge & (cur.a != cur.b);
        dn = a_edge & (cur.a == cur.b);
      end
      servo_cfg_pkg::PM_QUAD_X4: begin
        // every edge counts; both phases moving at once is a glitch and dropped
        up = (a_edge & ~b_edge & (cur.a != cur.b)) | (b_edge & ~a_edge & (cur.a == cur.b));
        dn = (a_edge & ~b_edge & (cur.a == cur.b)) | (b_edge & ~a_edge & (cur.a != cur.b));
      end
      default: begin
        up = 1'b0;
        dn = 1'b0;
      end
    endcase
  end

  // first cycle after reset only primes the edge history
  always_ff @(posedge clk) begin
    if (rst) begin
      prev_q  <= '0;
      armed_q <= 1'b0;
      step_up <= 1'b0;
      step_dn <= 1'b0;
    end else begin
      prev_q  <= cur;
      armed_q <= 1'b1;
      step_up <= armed_q & (reverse ? dn : up);
      step_dn <= armed_q & (reverse ? up : dn);
    end
  end

endmodule

// ### servo_setup_chk.sv
// assertions on the servo setup decode ports
`timescale 1ns/1ps
module servo_setup_chk (
  // clock and reset
  input wire logic                           clk,
  input wire logic                           rst,
  // setup access
  input wire logic                           wr_two,
  input wire logic [15:0]                    wr_data,
  input wire logic                           factory_init,
  input wire logic                           power_cycle,
  input wire logic [15:0]                    word_one_rd,
  // status and counting
  input wire logic                           dev_clear_pin,
  input wire servo_cfg_pkg::ctrl_mode_type   ctrl_mode,
  input wire logic                           fb_step_up,
  input wire logic                           fb_step_dn,
  input wire logic                           cmd_step_up,
  input wire logic                           cmd_step_dn,
  input wire servo_cfg_pkg::dev_type         deviation,
  input wire logic                           servo_on,
  // decoded settings
  input wire servo_cfg_pkg::mon1_src_type    first_monitor_output,
  input wire servo_cfg_pkg::mon2_src_type    second_monitor_output,
  input wire servo_cfg_pkg::mode_flags_type  flags,
  input wire logic [1:0]                     psw_cond
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  logic [2:0] quiet_q;
  // clear pin needs two sync stages and an edge detect to settle
  always_ff @(posedge clk) quiet_q <= (rst | dev_clear_pin) ? 3'h0 : (quiet_q == 3'h7 ? quiet_q : quiet_q + 3'h1);
  sequence s_settle;
    !wr_two && !factory_init;
  endsequence
  AST_MON1_CUR: assert property (
    wr_two && !factory_init && !wr_data[6] ##1 s_settle |=> first_monitor_output == servo_cfg_pkg::MON1_CURRENT)
    else $error("monitor one not current after write");
  AST_MON2_DEV: assert property (
    wr_two && !factory_init && wr_data[7] && ctrl_mode == servo_cfg_pkg::CTRL_POSITION
    ##1 (s_settle and ctrl_mode == servo_cfg_pkg::CTRL_POSITION)
    |=> second_monitor_output == servo_cfg_pkg::MON2_DEVIATION)
    else $error("monitor two not deviation after write");
  AST_DEV_CNT: assert property (
    (cmd_step_up ^ cmd_step_dn) && !fb_step_up && !fb_step_dn && quiet_q == 3'h7 && servo_on && $past(servo_on)
    |=> deviation == $past(deviation) + ($past(cmd_step_up) ? 16'h0001 : 16'hFFFF))
    else $error("deviation did not follow command step");
  AST_STEP_ONE: assert property (cmd_step_up |-> !cmd_step_dn)
    else $error("up and down steps together");
  AST_PSW_HOLD: assert property (!power_cycle [*2] |=> $stable(psw_cond))
    else $error("switch condition changed without power reset");
  AST_ENC: assert property (
    power_cycle ##1 !power_cycle |=> ##1 flags.absolute_enc == $past(word_one_rd[14], 3))
    else $error("encoder type not taken at power reset");
  AST_PSW_TRQ: assert property (ctrl_mode == servo_cfg_pkg::CTRL_TORQUE [*2] |=> !flags.psw_en)
    else $error("proportional switch enabled in torque control");
  AST_FF_SPD: assert property (
    ctrl_mode != servo_cfg_pkg::CTRL_SPEED [*2] |=> !flags.torque_ff_en && !flags.current_lim_en)
    else $error("speed control feature active outside speed control");
  AST_LIM_TRQ: assert property (ctrl_mode != servo_cfg_pkg::CTRL_TORQUE [*2] |=> !flags.speed_lim_en)
    else $error("analog speed limit active outside torque control");
endmodule

// ### pulse_host_model.sv
// host controller model driving the command pulse pins
`timescale 1ns/1ps
module pulse_host_model (
  // clock
  input wire logic                      clk,
  // command pulse pins
  output servo_cfg_pkg::pulse_pins_type pins
);
  logic inv = 1'b0;
  initial pins = 2'h0;
  // only call while the old format is PM_QUAD_X4 if both pins may flip together
  task automatic idle(input logic neg);
    inv = neg;
    pins = {neg, neg};
  endtask
  // one pulse; quadrature sends one full cycle with phase a leading for up
  task automatic send(input logic [2:0] mode, input logic dn, input int hold);
    logic [7:0] pat;
    pat = (mode == servo_cfg_pkg::PM_PULSE_DIR) ? (dn ? 8'h75 : 8'h20) :
          (mode == servo_cfg_pkg::PM_FWD_REV) ? (dn ? 8'h40 : 8'h80) : (dn ? 8'h78 : 8'hB4);
    for (int i = 3; i >= 0; i--) begin
      pins = {pat[2*i+1], pat[2*i]} ^ {inv, inv};
      repeat (hold) @(negedge clk);
    end
  endtask
endmodule

// ### tb_top.sv
// testbench for the servo setup decode block
`timescale 1ns/1ps
module tb_top;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic wr_one = 1'b0;
  logic wr_two = 1'b0;
  logic factory_init = 1'b0;
  logic power_cycle = 1'b0;
  logic dev_clear_pin = 1'b0;
  logic alarm = 1'b0;
  logic ot = 1'b0, fb_up = 1'b0, fb_dn = 1'b0;
  logic motor_stopped = 1'b0;
  logic origin_err_raw = 1'b0;
  logic [15:0] wr_data = 16'h0000;
  servo_cfg_pkg::ctrl_mode_type ctrl_mode = servo_cfg_pkg::CTRL_POSITION;
  servo_cfg_pkg::pulse_pins_type pins;
  logic cmd_step_up, cmd_step_dn, servo_on;
  logic [15:0] word_one_rd, word_two_rd;
  servo_cfg_pkg::dev_type deviation;
  servo_cfg_pkg::mon1_src_type mon1;
  servo_cfg_pkg::mon2_src_type mon2;
  servo_cfg_pkg::mode_flags_type flags;
  servo_cfg_pkg::stop_out_type stop_out;
  int n_mismatch = 0;
  int cmp_count = 0;
  int n_up = 0;
  int n_dn = 0;
  // reserved bits b and F kept zero in every word two value
  logic [15:0] rows [8] = '{16'h0400, 16'h0408, 16'h0410, 16'h0418, 16'h0420, 16'h2420, 16'h0421, 16'h0020};
  initial forever #2 clk = ~clk;
  always @(posedge clk) begin
    n_up <= n_up + int'(cmd_step_up);
    n_dn <= n_dn + int'(cmd_step_dn);
  end
  pulse_host_model i_pulse_host_model (.clk(clk), .pins(pins));
  servo_setup_pulse_config i_servo_setup_pulse_config (
    .clk(clk), .rst(rst), .wr_one(wr_one), .wr_two(wr_two), .wr_data(wr_data), .factory_init(factory_init),
    .power_cycle(power_cycle), .word_one_rd(word_one_rd), .word_two_rd(word_two_rd), .motor_large_pin(1'b0),
    .feed_pulse_input(pins), .dev_clear_pin(dev_clear_pin), .ctrl_mode(ctrl_mode), .run_cmd(1'b1),
    .sensor_on_in(1'b1), .fwd_prohibit(1'b0), .rev_prohibit(1'b0), .alarm(alarm), .overtravel(ot),
    .motor_stopped(motor_stopped), .origin_err_raw(origin_err_raw), .fb_step_up(fb_up), .fb_step_dn(fb_dn),
    .cmd_step_up(cmd_step_up), .cmd_step_dn(cmd_step_dn), .deviation(deviation), .servo_on(servo_on),
    .drive_fwd_ok(), .drive_rev_ok(), .first_monitor_output(mon1), .second_monitor_output(mon2),
    .flags(flags), .psw_cond(), .stop_out(stop_out));
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic two, input logic [15:0] d);
    wr_one = ~two;
    wr_two = two;
    wr_data = d;
    @(negedge clk);
    wr_one = 1'b0;
    wr_two = 1'b0;
    @(negedge clk);
  endtask
  task automatic pcyc;
    power_cycle = 1'b1;
    @(negedge clk);
    power_cycle = 1'b0;
    repeat (4) @(negedge clk);
  endtask
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge clk);
    n_mismatch++;
    complete_run();
  end
  initial begin
    logic [15:0] w;
    int m, s, u0, d0;
    repeat (12) @(negedge clk);
    rst = 1'b0;
    repeat (6) @(negedge clk);
    check("word_two", word_two_rd, servo_cfg_pkg::W2_FACTORY);
    check("format", word_two_rd[5:3], servo_cfg_pkg::PM_FWD_REV);
    check("brake_bit", word_one_rd[7], 1'b1);
    // every format, polarity, sense and clear mode; odd rows hold the up pulse levels longer
    for (int r = 0; r < 8; r++) begin
      w = rows[r];
      m = (w[5:3] == 3'h3) ? 2 : ((w[5:3] == 3'h4) ? 4 : 1);
      s = w[0] ? -1 : 1;
      wr(1'b1, w);
      i_pulse_host_model.idle(w[13]);
      pcyc();
      dev_clear_pin = 1'b1;
      repeat (6) @(negedge clk);
      check("dev_clear", deviation, 16'h0000);
      u0 = n_up;
      d0 = n_dn;
      i_pulse_host_model.send(w[5:3], 1'b0, 2 + 3 * (r % 2));
      repeat (4) @(negedge clk);
      check("steps_up", w[0] ? n_dn - d0 : n_up - u0, m);
      check("dev_up", deviation, w[10] ? m * s : 0);
      dev_clear_pin = 1'b0;
      repeat (6) @(negedge clk);
      i_pulse_host_model.send(w[5:3], 1'b1, 2);
      repeat (4) @(negedge clk);
      check("steps_dn", w[0] ? n_up - u0 : n_dn - d0, m);
      check("dev_dn", deviation, w[10] ? 0 : -m * s);
    end
    wr(1'b1, 16'h47CC);
    wr(1'b0, 16'h40CC);
    repeat (3) @(negedge clk);
    check("mon1", mon1, servo_cfg_pkg::MON1_PULSE_SPEED);
    check("mon2", mon2, servo_cfg_pkg::MON2_DEVIATION);
    check("x100", flags.dev_mon_x100, 1'b0);
    check("abs", flags.absolute_enc, 1'b0);
    origin_err_raw = 1'b1;
    pcyc();
    check("x100", flags.dev_mon_x100, 1'b1);
    check("abs", flags.absolute_enc, 1'b1);
    check("origin", flags.origin_err, 1'b1);
    check("psw", flags.psw_en, 1'b1);
    ctrl_mode = servo_cfg_pkg::CTRL_SPEED;
    repeat (3) @(negedge clk);
    check("mon1", mon1, servo_cfg_pkg::MON1_SPEED_CMD);
    check("mon2", mon2, servo_cfg_pkg::MON2_ZERO);
    check("flags", flags[7:5], 3'b011);
    ctrl_mode = servo_cfg_pkg::CTRL_TORQUE;
    repeat (3) @(negedge clk);
    check("mon1", mon1, servo_cfg_pkg::MON1_ZERO);
    check("flags", flags[7:4], 4'b1000);
    ctrl_mode = servo_cfg_pkg::CTRL_POSITION;
    alarm = 1'b1;
    repeat (3) @(negedge clk);
    check("free_run", stop_out.free_run, 1'b1);
    motor_stopped = 1'b1;
    repeat (3) @(negedge clk);
    check("brake", stop_out.dyn_brake, 1'b0);
    alarm = 1'b0;
    motor_stopped = 1'b0;
    ot = 1'b1;
    repeat (3) @(negedge clk);
    check("ot_free", stop_out.free_run, 1'b1);
    motor_stopped = 1'b1;
    repeat (3) @(negedge clk);
    check("ot_off", stop_out[1:0], 2'b10);
    ot = 1'b0;
    motor_stopped = 1'b0;
    factory_init = 1'b1;
    @(negedge clk);
    factory_init = 1'b0;
    @(negedge clk);
    check("word_two", word_two_rd, servo_cfg_pkg::W2_FACTORY);
    fb_dn = 1'b1;
    @(negedge clk);
    fb_dn = 1'b0;
    @(negedge clk);
    check("dev_fb", deviation, 16'h0001);
    complete_run();
  end
endmodule
bind servo_setup_pulse_config servo_setup_chk i_servo_setup_chk (
  .clk(clk), .rst(rst), .wr_two(wr_two), .wr_data(wr_data), .factory_init(factory_init), .power_cycle(power_cycle),
  .word_one_rd(word_one_rd), .dev_clear_pin(dev_clear_pin), .ctrl_mode(ctrl_mode), .fb_step_up(fb_step_up),
  .fb_step_dn(fb_step_dn), .cmd_step_up(cmd_step_up), .cmd_step_dn(cmd_step_dn), .deviation(deviation),
  .servo_on(servo_on), .first_monitor_output(first_monitor_output), .second_monitor_output(second_monitor_output),
  .flags(flags), .psw_cond(psw_cond));
